// >>> design/fsc_pkg.sv
// Package with the constants and carrier types shared by the fan drive slew logic.
package fsc_pkg;

  localparam int FAN_N = 4;
  localparam int DRIVE_W = 9;
  localparam int COUNT_W = 11;
  localparam int DRIVE_STEPS = 512;
  localparam logic [8:0] DRIVE_ZERO = 9'h000;
  localparam logic [8:0] DRIVE_FULL = 9'h1FF;
  localparam logic [10:0] COUNT_SHUTDOWN = 11'h7FF;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] FAN1_DYNAMICS_ADDR = 8'h06;
  localparam logic [7:0] FAN2_DYNAMICS_ADDR = 8'h07;
  localparam logic [7:0] FAN3_DYNAMICS_ADDR = 8'h08;
  localparam logic [7:0] FAN4_DYNAMICS_ADDR = 8'h09;
  localparam logic [7:0] DYNAMICS_RESET = 8'h4C;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int RATE_LSB = 2;
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_ZERO = 3'h0;

  localparam int CLK_MHZ = 100;
  localparam int TIMER_W = 32;
  // Interval forced in speed-regulated mode when the rate field selects zero.
  localparam int SPEED_MIN_INTERVAL_US = 62500;
  localparam int SPEED_MIN_INTERVAL_CYC = SPEED_MIN_INTERVAL_US * CLK_MHZ;
  // Interval per rate code count for nonzero codes; a plain default.
  localparam int RATE_UNIT_US = 62500;
  localparam int RATE_UNIT_CYC = RATE_UNIT_US * CLK_MHZ;

  typedef struct packed {
    logic speed_mode;
    logic spinup_en;
    logic [10:0] target_count;
    logic [8:0] target_drive;
    logic loop_up;
    logic loop_down;
  } fsc_fan_in_t;

  typedef struct packed {
    logic [8:0] drive;
    logic spinup_start;
    logic settled;
  } fsc_fan_out_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsc_reg_req_t;

endpackage : fsc_pkg

// >>> design/fsc_dyn_regs.sv
// Storage for the four per-fan dynamics registers with a registered read port.
`timescale 1ns/1ps
module fsc_dyn_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [fsc_pkg::FAN_N-1:0] wr_sel,
  input wire logic [fsc_pkg::FAN_N-1:0] rd_sel,
  input wire logic rd_en,
  input wire logic [fsc_pkg::DATA_W-1:0] wdata,
  output logic [fsc_pkg::DATA_W-1:0] rdata,
  output logic [fsc_pkg::FAN_N-1:0][fsc_pkg::DATA_W-1:0] dyn
);
  import fsc_pkg::*;

  logic [DATA_W-1:0] rdata_next;

  genvar gi;
  generate
    for (gi = 0; gi < FAN_N; gi++) begin : g_reg
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          dyn[gi] <= DYNAMICS_RESET;
        end else if (wr_sel[gi]) begin
          dyn[gi] <= wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_next = UNMAPPED_READ;
    for (int i = 0; i < FAN_N; i++) begin
      if (rd_sel[i]) begin
        rdata_next = dyn[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= UNMAPPED_READ;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end
  end

endmodule : fsc_dyn_regs

// >>> design/fsc_slew_top.sv
// Four-fan drive slew control with the dynamics register port.
//
// Operation
// RL1: Drive moves in single steps of 1/512.
// RL2: Rate field sets time between steps.
// RL3: Speed mode rate zero uses 0.0625 s.
// RL4: Target count 2047 forces drive zero immediately.
// RL5: Target drive zero forces output zero immediately.
// RL6: Direct mode restart from zero jumps to target.
// RL7: Speed mode restart loads target drive value.
// RL8: Host steps down before selecting shutdown.
// RL9: One step per interval, stop at target.
`timescale 1ns/1ps
// Interval lengths are counted in clock cycles. The defaults give the real durations at the
// system clock rate; a bench may shrink them to keep its runs short.
module fsc_slew_top #(
  parameter logic [31:0] SPEED_MIN_CYC = 32'(fsc_pkg::SPEED_MIN_INTERVAL_CYC),
  parameter logic [31:0] RATE_UNIT_CYCLES = 32'(fsc_pkg::RATE_UNIT_CYC)
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire fsc_pkg::fsc_reg_req_t reg_req,
  output logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  input wire fsc_pkg::fsc_fan_in_t [fsc_pkg::FAN_N-1:0] fan_in,
  output fsc_pkg::fsc_fan_out_t [fsc_pkg::FAN_N-1:0] fan_out
);
  import fsc_pkg::*;

  // One-hot fan select for a register address; zero for an unmapped address.
  function automatic logic [FAN_N-1:0] fan_select(input logic [ADDR_W-1:0] addr);
    logic [FAN_N-1:0] sel;
    sel = '0;
    case (addr)
      FAN1_DYNAMICS_ADDR: sel = 4'h1;
      FAN2_DYNAMICS_ADDR: sel = 4'h2;
      FAN3_DYNAMICS_ADDR: sel = 4'h4;
      FAN4_DYNAMICS_ADDR: sel = 4'h8;
      default: sel = '0;
    endcase
    return sel;
  endfunction : fan_select

  // Step interval in clock cycles for one rate code. Rate zero would let the speed loop ring, so
  // speed mode falls back to the shortest safe interval, while direct mode steps every cycle.
  function automatic logic [TIMER_W-1:0] step_interval(input logic [RATE_W-1:0] code, input logic speed);
    logic [TIMER_W-1:0] cyc;
    cyc = '0;
    if (code == RATE_ZERO) begin
      cyc = speed ? SPEED_MIN_CYC : 32'h0000_0001; // RL3
    end else begin
      cyc = TIMER_W'(RATE_UNIT_CYCLES * code); // RL2
    end
    return cyc;
  endfunction : step_interval

  // Direction of the next step, up in bit 1 and down in bit 0. A conflicting loop demand asks for
  // neither, and the rails stop any step that would wrap the drive around.
  function automatic logic [1:0] step_dir(input fsc_fan_in_t fi, input logic [DRIVE_W-1:0] drive);
    logic [1:0] dir;
    dir = 2'h0;
    if (fi.speed_mode) begin
      dir[1] = fi.loop_up && !fi.loop_down && (drive != DRIVE_FULL);
      dir[0] = fi.loop_down && !fi.loop_up && (drive != DRIVE_ZERO);
    end else begin
      dir[1] = (drive < fi.target_drive);
      dir[0] = (drive > fi.target_drive);
    end
    return dir;
  endfunction : step_dir

  // Shutdown request of one fan, decoded from the value that each mode treats as stop.
  function automatic logic is_shutdown(input fsc_fan_in_t fi);
    logic off;
    off = 1'b0;
    if (fi.speed_mode) begin
      off = (fi.target_count == COUNT_SHUTDOWN); // RL4
    end else begin
      off = (fi.target_drive == DRIVE_ZERO); // RL5
    end
    return off;
  endfunction : is_shutdown

  // One drive step up or down; callers only step away from the rails.
  function automatic logic [DRIVE_W-1:0] step_once(input logic [DRIVE_W-1:0] drive, input logic up);
    logic [DRIVE_W-1:0] nxt;
    nxt = drive;
    if (up) begin
      nxt = drive + 9'h001; // RL1
    end else begin
      nxt = drive - 9'h001; // RL1
    end
    return nxt;
  endfunction : step_once

  logic [FAN_N-1:0] wr_sel;
  logic [FAN_N-1:0] rd_sel;
  logic [FAN_N-1:0][DATA_W-1:0] dyn;

  // The read select follows the address on every cycle. The read register only loads on re, so
  // an address change between reads leaves the data held for the host alone.
  assign wr_sel = reg_req.we ? fan_select(reg_req.addr) : '0;
  assign rd_sel = fan_select(reg_req.addr);

  fsc_dyn_regs u_regs (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_sel(wr_sel),
    .rd_sel(rd_sel),
    .rd_en(reg_req.re),
    .wdata(reg_req.wdata),
    .rdata(reg_rdata),
    .dyn(dyn)
  );

  // Each fan has its own timer, so channels never share or delay one another's steps.
  genvar gf;
  generate
    for (gf = 0; gf < FAN_N; gf++) begin : g_fan
      logic [RATE_W-1:0] rate_code;
      logic [TIMER_W-1:0] interval;
      logic [TIMER_W-1:0] timer_reg;
      logic [TIMER_W-1:0] timer_next;
      logic [DRIVE_W-1:0] drive_reg;
      logic [DRIVE_W-1:0] drive_next;
      logic spin_reg;
      logic spin_next;
      logic settled_reg;
      logic settled_next;
      logic tick;
      logic shutdown;
      logic restart;
      logic jump;
      logic want_up;
      logic want_down;

      assign rate_code = dyn[gf][RATE_LSB +: RATE_W];

      assign interval = step_interval(rate_code, fan_in[gf].speed_mode); // RL2 RL3

      assign tick = (timer_reg >= interval - 32'h0000_0001);

      // Shutdown is held as a level, so it also wins over any step in flight.
      assign shutdown = is_shutdown(fan_in[gf]); // RL4 RL5

      assign restart = (drive_reg == DRIVE_ZERO) && !shutdown;

      // In speed mode a zero restart value gives no jump; the drive then waits at zero and the
      // loop demand steps it up one interval at a time.
      assign jump = restart && (fan_in[gf].target_drive != DRIVE_ZERO);

      assign {want_up, want_down} = step_dir(fan_in[gf], drive_reg);

      // Shutdown outranks a restart jump and a jump outranks a step, so a host that selects the
      // stop value in the middle of a ramp gets zero drive at once.
      always_comb begin
        drive_next = drive_reg;
        spin_next = 1'b0;
        if (shutdown) begin
          drive_next = DRIVE_ZERO; // RL4 RL5
        end else if (jump) begin
          // Both modes restart from the target drive value in one move.
          drive_next = fan_in[gf].target_drive; // RL6 RL7
          spin_next = fan_in[gf].spinup_en; // RL6 RL7
        end else if (tick && want_up) begin
          drive_next = step_once(drive_reg, 1'b1); // RL1 RL9
        end else if (tick && want_down) begin
          drive_next = step_once(drive_reg, 1'b0); // RL1 RL9
        end
      end

      // The timer restarts after every step or jump so the next step waits a
      // whole interval; a shorter rate code takes effect at once, in the interval already running.
      always_comb begin
        if (shutdown || jump || tick) begin
          timer_next = '0; // RL9
        end else begin
          timer_next = timer_reg + 32'h0000_0001;
        end
      end

      // Settled trails the drive by one cycle, since it is registered like every other output.
      // It stays low while a step or a restart jump is still due.
      assign settled_next = !want_up && !want_down && !jump;

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          drive_reg <= DRIVE_ZERO;
        end else begin
          drive_reg <= drive_next;
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          timer_reg <= '0;
        end else begin
          timer_reg <= timer_next;
        end
      end

      // The spin-up start is a single-cycle pulse; the drive itself jumps in the same cycle, so
      // the stage behind the pin must run its spin-up from this pulse alone.
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          spin_reg <= 1'b0;
        end else begin
          spin_reg <= spin_next;
        end
      end

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          settled_reg <= 1'b0;
        end else begin
          settled_reg <= settled_next;
        end
      end

      // All three outputs come straight from the registers above.
      assign fan_out[gf].drive = drive_reg;
      assign fan_out[gf].spinup_start = spin_reg;
      assign fan_out[gf].settled = settled_reg;
    end
  endgenerate

endmodule : fsc_slew_top

// >>> sim/fsc_slew_props.sv
// Checker with the slew and jump properties of the first fan channel.
`timescale 1ns/1ps
module fsc_slew_props #(
  parameter logic [31:0] SPEED_MIN_CYC = 32'h8,
  parameter logic [31:0] RATE_UNIT_CYCLES = 32'h4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire fsc_pkg::fsc_reg_req_t reg_req,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  input wire fsc_pkg::fsc_fan_in_t [fsc_pkg::FAN_N-1:0] fan_in,
  input wire fsc_pkg::fsc_fan_out_t [fsc_pkg::FAN_N-1:0] fan_out
);
  import fsc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [8:0] d;
  logic [8:0] t;
  logic [8:0] pd;
  logic s;
  logic [2:0] rc;
  logic [31:0] gap;
  assign d = fan_out[0].drive;
  assign t = fan_in[0].target_drive;
  assign s = fan_in[0].speed_mode;
  // The gap counts cycles since the drive last moved, so early steps are seen.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pd <= DRIVE_ZERO;
      gap <= 32'h0;
      rc <= DYNAMICS_RESET[RATE_LSB +: RATE_W];
    end else begin
      pd <= d;
      gap <= (d != pd) ? 32'h1 : gap + 32'h1;
      if (reg_req.we && reg_req.addr == FAN1_DYNAMICS_ADDR) rc <= reg_req.wdata[RATE_LSB +: RATE_W];
    end
  end
  property p_one_step;
    d != pd && pd != DRIVE_ZERO && d != DRIVE_ZERO |-> d == pd + 9'h1 || d == pd - 9'h1;
  endproperty
  a_one_step: assert property (p_one_step) else $error("drive moved by more than one step");
  property p_count_off;
    s && fan_in[0].target_count == COUNT_SHUTDOWN |=> d == DRIVE_ZERO;
  endproperty
  a_count_off: assert property (p_count_off) else $error("drive not cut on full count");
  property p_drive_off;
    !s && t == DRIVE_ZERO |=> d == DRIVE_ZERO;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive not cut on zero target");
  property p_direct_jump;
    !s && d == DRIVE_ZERO && t != DRIVE_ZERO |=> d == $past(t);
  endproperty
  a_direct_jump: assert property (p_direct_jump) else $error("direct restart did not jump");
  property p_speed_jump;
    s && fan_in[0].target_count != COUNT_SHUTDOWN && d == DRIVE_ZERO && t != DRIVE_ZERO |=> d == $past(t);
  endproperty
  a_speed_jump: assert property (p_speed_jump) else $error("speed restart did not load");
  property p_spin_pulse;
    fan_out[0].spinup_start |-> d != DRIVE_ZERO && pd == DRIVE_ZERO && $past(fan_in[0].spinup_en);
  endproperty
  a_spin_pulse: assert property (p_spin_pulse) else $error("spin-up pulse outside restart");
  property p_hold;
    !s && d == t |=> $stable(d);
  endproperty
  a_hold: assert property (p_hold) else $error("drive moved at target");
  property p_interval;
    d != pd && pd != DRIVE_ZERO && d != DRIVE_ZERO |->
      gap >= ((rc == RATE_ZERO) ? (s ? SPEED_MIN_CYC : 32'h1) : RATE_UNIT_CYCLES * rc);
  endproperty
  a_interval: assert property (p_interval) else $error("step came too early");
  property p_spin_on;
    !s && d == DRIVE_ZERO && t != DRIVE_ZERO && fan_in[0].spinup_en |=> fan_out[0].spinup_start;
  endproperty
  a_spin_on: assert property (p_spin_on) else $error("no spin-up pulse on direct restart");
  property p_settled;
    !s |=> fan_out[0].settled == ($past(d) == $past(t));
  endproperty
  a_settled: assert property (p_settled) else $error("settled flag disagrees with target");
endmodule : fsc_slew_props

// >>> sim/fsc_fan_model.sv
// Behavioural fan with its speed loop demand for one channel.
`timescale 1ns/1ps
module fsc_fan_model (
  input wire logic [8:0] drive,
  input wire logic [8:0] setpoint,
  output logic loop_up,
  output logic loop_down
);
  // Speed follows drive with no lag, so the loop settles exactly at the setpoint.
  assign loop_up = drive < setpoint;
  assign loop_down = drive > setpoint;
endmodule : fsc_fan_model

// >>> sim/tb_top.sv
// Self-checking bench for the four-fan drive slew control.
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  fsc_reg_req_t reg_req = '0;
  logic [DATA_W-1:0] reg_rdata;
  fsc_fan_in_t f0 = '0;
  logic [71:0] rnd = '0;
  wire fsc_fan_in_t [FAN_N-1:0] fan_in;
  fsc_fan_out_t [FAN_N-1:0] fan_out;
  logic [8:0] setp = '0;
  logic up;
  logic dn;
  logic re_d = 1'b0;
  logic [8:0] seen = '0;
  logic [7:0] v;
  int seed = 32'h209dc42b;
  int miscompares = 0;
  int samples_checked = 0;
  logic [8:0] dq[$];
  logic [7:0] rq[$];
  assign fan_in = {rnd, f0.speed_mode, f0.spinup_en, f0.target_count, f0.target_drive, up, dn};
  fsc_slew_top #(.SPEED_MIN_CYC(32'h8), .RATE_UNIT_CYCLES(32'h4)) u_fsc_slew_top (.core_clk(core_clk),
    .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata), .fan_in(fan_in), .fan_out(fan_out));
  fsc_fan_model u_fsc_fan_model (.drive(fan_out[0].drive), .setpoint(setp), .loop_up(up), .loop_down(dn));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) rnd <= 72'({$random(seed), $random(seed), $random(seed)});
  always @(posedge core_clk) re_d <= reg_req.re;
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // Every drive change must match the oldest expected value, so skipped or extra steps show.
  always @(negedge core_clk) begin
    if (re_d) check({1'b0, reg_rdata}, {1'b0, rq.pop_front()});
    if (nrst && fan_out[0].drive !== seen) begin
      seen = fan_out[0].drive;
      check(seen, dq.size() ? dq.pop_front() : ~seen);
    end
  end
  task automatic reg_op(input logic we, input logic [7:0] a, input logic [7:0] val);
    @(posedge core_clk);
    reg_req <= '{we: we, re: !we, addr: a, wdata: val};
    if (!we) rq.push_back(val);
    @(posedge core_clk);
    reg_req <= '0;
  endtask : reg_op
  task automatic wait_drive(input logic [8:0] val);
    int n = 0;
    while (fan_out[0].drive !== val && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (fan_out[0].drive !== val) begin
      miscompares++;
      test_done();
    end
  endtask : wait_drive
  task automatic set_td(input logic [8:0] val);
    @(posedge core_clk);
    f0.target_drive <= val;
  endtask : set_td
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 6; a < 11; a++) reg_op(1'b0, 8'(a), (a < 10) ? DYNAMICS_RESET : UNMAPPED_READ);
    v = 8'($random(seed));
    reg_op(1'b1, FAN2_DYNAMICS_ADDR, v);
    reg_op(1'b0, FAN2_DYNAMICS_ADDR, v);
    reg_op(1'b1, FAN1_DYNAMICS_ADDR, 8'h00);
    dq = '{9'h005, 9'h006, 9'h007, 9'h008, 9'h007, 9'h006, 9'h000};
    f0.spinup_en <= 1'b1;
    set_td(9'h005);
    wait_drive(9'h005);
    set_td(9'h008);
    wait_drive(9'h008);
    reg_op(1'b1, FAN1_DYNAMICS_ADDR, 8'h04);
    set_td(9'h006);
    wait_drive(9'h006);
    set_td(9'h000);
    wait_drive(9'h000);
    reg_op(1'b1, FAN1_DYNAMICS_ADDR, 8'h00);
    dq = '{9'h010, 9'h011, 9'h012, 9'h011, 9'h000};
    setp <= 9'h012;
    f0.speed_mode <= 1'b1;
    set_td(9'h010);
    wait_drive(9'h012);
    // The host backs the fan down before asking for shutdown.
    @(posedge core_clk);
    setp <= 9'h011;
    wait_drive(9'h011);
    @(posedge core_clk);
    f0.target_count <= COUNT_SHUTDOWN;
    wait_drive(9'h000);
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule : tb_top
bind fsc_slew_top fsc_slew_props #(.SPEED_MIN_CYC(SPEED_MIN_CYC), .RATE_UNIT_CYCLES(RATE_UNIT_CYCLES))
  u_fsc_slew_props (.core_clk(core_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .fan_in(fan_in), .fan_out(fan_out));
